// *** stb_pkg.sv ***
package stb_pkg;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned ID_COUNT     = 8;
  localparam logic [2:0]  OWN_ID_RESET = 3'h5;
  localparam logic [2:0]  LUN_FIXED    = 3'h0;
  localparam int unsigned BUF_DEPTH    = 2;

  typedef enum logic [2:0] {
    STB_PH_DATA = 3'h0,
    STB_PH_CMD  = 3'h2,
    STB_PH_STAT = 3'h3,
    STB_PH_MOUT = 3'h6,
    STB_PH_MIN  = 3'h7
  } stb_phase_t;

  function automatic logic stb_odd_parity(input logic [DATA_W-1:0] d);
    return ~(^d);
  endfunction
endpackage

// *** stb_bus_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// all *_n fields carry the electrical (active-low) line level; *_oe high while driving
interface stb_bus_if;
  logic       bsy_n;
  logic       sel_n;
  logic       cd_n;
  logic       io_n;
  logic       msg_n;
  logic       req_n;
  logic       ack_n;
  logic       atn_n;
  logic       rst_n;
  logic [7:0] db_n;
  logic       dbp_n;
  logic       t_bsy_oe;
  logic       t_sel_oe;
  logic       t_ctl_oe;
  logic       t_cd_o;
  logic       t_io_o;
  logic       t_msg_o;
  logic       t_req_o;
  logic       t_rst_oe;
  logic [7:0] t_db_oe;
  logic       t_dbp_oe;
  logic [7:0] t_db_o;
  logic       t_dbp_o;
  logic       i_bsy_oe;
  logic       i_sel_oe;
  logic       i_ack_oe;
  logic       i_atn_oe;
  logic       i_rst_oe;
  logic [7:0] i_db_oe;
  logic       i_dbp_oe;
  logic [7:0] i_db_o;
  logic       i_dbp_o;

  // wired-or lines: any enabled driver asserting a line pulls it low, terminator pulls high
  assign bsy_n = ~(t_bsy_oe | i_bsy_oe);
  assign sel_n = ~(t_sel_oe | i_sel_oe);
  assign rst_n = ~(t_rst_oe | i_rst_oe);
  assign ack_n = ~i_ack_oe;
  assign atn_n = ~i_atn_oe;
  assign cd_n  = t_ctl_oe ? ~t_cd_o : 1'b1;
  assign io_n  = t_ctl_oe ? ~t_io_o : 1'b1;
  assign msg_n = t_ctl_oe ? ~t_msg_o : 1'b1;
  assign req_n = t_ctl_oe ? ~t_req_o : 1'b1;
  assign db_n  = ~((t_db_oe & t_db_o) | (i_db_oe & i_db_o));
  assign dbp_n = ~((t_dbp_oe & t_dbp_o) | (i_dbp_oe & i_dbp_o));

  modport target (
    input  bsy_n, sel_n, ack_n, atn_n, rst_n, db_n, dbp_n,
    output t_bsy_oe, t_sel_oe, t_ctl_oe, t_cd_o, t_io_o, t_msg_o, t_req_o,
    output t_rst_oe, t_db_oe, t_dbp_oe, t_db_o, t_dbp_o
  );
  modport initiator (
    input  bsy_n, sel_n, cd_n, io_n, msg_n, req_n, rst_n, db_n, dbp_n,
    output i_bsy_oe, i_sel_oe, i_ack_oe, i_atn_oe, i_rst_oe,
    output i_db_oe, i_dbp_oe, i_db_o, i_dbp_o
  );
endinterface
`default_nettype wire

// *** stb_buf2.sv ***
`timescale 1ns/1ps
`default_nettype none
// two-entry skid buffer; in_ready_o drops only when both entries hold words
module stb_buf2 #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic                  rd;
    logic                  wr;
    logic [1:0]            cnt;
  } stb_buf_st_t;

  stb_buf_st_t st_reg;
  stb_buf_st_t st_next;
  logic        push;
  logic        pop;

  assign in_ready_o  = (st_reg.cnt != 2'h2);
  assign out_valid_o = (st_reg.cnt != 2'h0);
  assign out_data_o  = st_reg.mem[st_reg.rd];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb
  begin
    st_next = st_reg;
    if (push)
    begin
      st_next.mem[st_reg.wr] = in_data_i;
      st_next.wr             = ~st_reg.wr;
    end
    if (pop)
      st_next.rd = ~st_reg.rd;
    if (push && !pop)
      st_next.cnt = st_reg.cnt + 2'h1;
    else if (pop && !push)
      st_next.cnt = st_reg.cnt - 2'h1;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
endmodule
`default_nettype wire

// *** stb_target.sv ***
`timescale 1ns/1ps
`default_nettype none
module stb_target #(
  parameter int unsigned ID_W = 3
) (
  input  wire logic                        clock_i,
  input  wire logic                        rst_n_i,
  stb_bus_if.target                        bus,
  input  wire logic [ID_W-1:0]             own_id_i,
  input  wire logic                        own_id_load_i,
  output logic [ID_W-1:0]                  own_id_o,
  output logic [ID_W-1:0]                  lun_o,
  input  wire logic                        resel_i,
  input  wire logic [ID_W-1:0]             resel_id_i,
  input  wire logic [2:0]                  phase_i,
  input  wire logic                        xfer_valid_i,
  output logic                             xfer_ready_o,
  input  wire logic [stb_pkg::DATA_W-1:0]  xfer_data_i,
  input  wire logic                        release_i,
  output logic                             rx_valid_o,
  input  wire logic                        rx_ready_i,
  output logic [stb_pkg::DATA_W-1:0]       rx_data_o,
  output logic                             connected_o,
  output logic [ID_W-1:0]                  peer_id_o,
  output logic                             selected_o,
  output logic                             atn_o,
  output logic                             bus_reset_o,
  output logic                             bus_busy_o,
  output logic                             parity_err_o
);
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_RSEL  = 5'b00010,
    ST_CONN  = 5'b00100,
    ST_REQ   = 5'b01000,
    ST_ACKW  = 5'b10000
  } stb_state_t;

  typedef struct packed {
    stb_state_t                  state;
    logic [ID_W-1:0]             own_id;
    logic [ID_W-1:0]             peer;
    logic [2:0]                  phase;
    logic [stb_pkg::DATA_W-1:0]  dout;
    logic                        drive_db;
    logic                        sel_drv;
    logic                        selected;
    logic                        perr;
  } stb_tgt_st_t;

  stb_tgt_st_t st_reg;
  stb_tgt_st_t st_next;

  logic [stb_pkg::DATA_W-1:0] db;
  logic                       dbp;
  logic                       bsy;
  logic                       sel;
  logic                       ack;
  logic                       rst;
  logic                       rx_push;
  logic                       rx_ready;
  logic                       in_dir;
  logic [stb_pkg::DATA_W-1:0] own_bit;
  logic [stb_pkg::DATA_W-1:0] peer_bit;
  logic [ID_W-1:0]            other_id;
  logic                       other_one;

  assign db  = ~bus.db_n;
  assign dbp = ~bus.dbp_n;
  assign bsy = ~bus.bsy_n;
  assign sel = ~bus.sel_n;
  assign ack = ~bus.ack_n;
  assign rst = ~bus.rst_n;

  assign own_bit  = stb_pkg::DATA_W'(1) << st_reg.own_id;
  assign peer_bit = stb_pkg::DATA_W'(1) << st_reg.peer;
  assign in_dir   = st_reg.phase[0];  // io bit: true means toward initiator

  // selection: own bit plus exactly one other bit; the I/O line is not examined
  always_comb
  begin
    other_id  = '0;
    other_one = 1'b0;
    for (int i = stb_pkg::ID_COUNT - 1; i >= 0; i--)
    begin
      if (db[i] && (i[ID_W-1:0] != st_reg.own_id))
      begin
        other_one = ~other_one | other_one;
        other_id  = i[ID_W-1:0];
      end
    end
    other_one = other_one && ($countones(db & ~own_bit) == 1);
  end

  stb_buf2 #(
    .WIDTH (stb_pkg::DATA_W)
  ) u_rx_buf (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (rx_push),
    .in_ready_o  (rx_ready),
    .in_data_i   (db),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_data_o)
  );

  always_comb
  begin
    st_next = st_reg;
    rx_push = 1'b0;
    if (own_id_load_i)
      st_next.own_id = own_id_i;
    case (st_reg.state)
      ST_IDLE:
      begin
        st_next.drive_db = 1'b0;
        st_next.sel_drv  = 1'b0;
        // never arbitrates: responds to selection, or reselects resel_id_i when resel_i is set
        if (sel && !bsy && db[st_reg.own_id] && other_one)
        begin
          st_next.peer     = other_id;
          st_next.selected = 1'b1;
          st_next.state    = ST_CONN;
        end
        else if (resel_i && !bsy && !sel)
        begin
          st_next.peer     = resel_id_i;
          st_next.sel_drv  = 1'b1;
          st_next.state    = ST_RSEL;
        end
      end
      ST_RSEL:
        // initiator answers reselection by raising busy; we then hold it ourselves
        if (bsy)
        begin
          st_next.sel_drv = 1'b0;
          st_next.state   = ST_CONN;
        end
      ST_CONN:
      begin
        st_next.selected = 1'b0;
        st_next.drive_db = 1'b0;
        if (release_i)
          st_next.state = ST_IDLE;
        // an out byte is only taken while the receive buffer has room, so request never stalls
        else if (xfer_valid_i && xfer_ready_o)
        begin
          st_next.phase    = phase_i;
          st_next.dout     = xfer_data_i;
          st_next.drive_db = phase_i[0];
          st_next.state    = ST_REQ;
        end
      end
      ST_REQ:
        // receive path must have room before request goes out, so no byte is lost
        if (ack && (in_dir || rx_ready))
        begin
          rx_push = ~in_dir;
          st_next.perr = ~in_dir && (dbp != stb_pkg::stb_odd_parity(db));
          st_next.state = ST_ACKW;
        end
      ST_ACKW:
      begin
        st_next.perr = 1'b0;
        if (!ack)
          st_next.state = ST_CONN;
      end
      default:
        st_next.state = ST_IDLE;
    endcase
    if (rst)
    begin
      st_next.state    = ST_IDLE;
      st_next.drive_db = 1'b0;
      st_next.sel_drv  = 1'b0;
      st_next.selected = 1'b0;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      st_reg        <= '0;
      st_reg.state  <= ST_IDLE;
      st_reg.own_id <= stb_pkg::OWN_ID_RESET;
    end
    else
      st_reg <= st_next;
  end

  // reserved lines have no port at all
  // busy is left to the initiator during reselection; reading it back here would close a loop
  assign bus.t_bsy_oe = (st_reg.state != ST_IDLE) && (st_reg.state != ST_RSEL);
  assign bus.t_sel_oe = st_reg.sel_drv;
  assign bus.t_ctl_oe = (st_reg.state != ST_IDLE);
  assign bus.t_cd_o   = (st_reg.state == ST_RSEL) ? 1'b0 : st_reg.phase[1];
  assign bus.t_io_o   = (st_reg.state == ST_RSEL) ? 1'b1 : st_reg.phase[0];
  assign bus.t_msg_o  = (st_reg.state != ST_RSEL) && st_reg.phase[2];
  assign bus.t_req_o  = (st_reg.state == ST_REQ);
  assign bus.t_rst_oe = 1'b0;
  assign bus.t_db_oe  = st_reg.sel_drv ? (own_bit | peer_bit)
                      : {stb_pkg::DATA_W{st_reg.drive_db}};
  assign bus.t_dbp_oe = st_reg.sel_drv | st_reg.drive_db;
  assign bus.t_db_o   = st_reg.sel_drv ? (own_bit | peer_bit) : st_reg.dout;
  assign bus.t_dbp_o  = stb_pkg::stb_odd_parity(bus.t_db_o);

  assign xfer_ready_o = (st_reg.state == ST_CONN) && !ack && !release_i && (phase_i[0] || rx_ready);
  assign own_id_o     = st_reg.own_id;
  assign lun_o        = stb_pkg::LUN_FIXED;
  assign connected_o  = (st_reg.state != ST_IDLE) && (st_reg.state != ST_RSEL);
  assign peer_id_o    = st_reg.peer;
  assign selected_o   = st_reg.selected;
  assign atn_o        = ~bus.atn_n;
  assign bus_reset_o  = rst;
  assign bus_busy_o   = bsy;
  assign parity_err_o = st_reg.perr;
endmodule
`default_nettype wire

// *** stb_initiator.sv ***
`timescale 1ns/1ps
`default_nettype none
// far end: selects a target, answers each request with acknowledge
module stb_initiator #(
  parameter int unsigned ID_W = 3
) (
  input  wire logic                        clock_i,
  input  wire logic                        rst_n_i,
  stb_bus_if.initiator                     bus,
  input  wire logic [ID_W-1:0]             own_id_i,
  input  wire logic                        select_i,
  input  wire logic [ID_W-1:0]             target_id_i,
  input  wire logic                        atn_i,
  input  wire logic                        bus_reset_i,
  input  wire logic [stb_pkg::DATA_W-1:0]  tx_data_i,
  output logic                             tx_taken_o,
  output logic                             rx_valid_o,
  output logic [stb_pkg::DATA_W-1:0]       rx_data_o,
  output logic [2:0]                       phase_o,
  output logic                             parity_err_o,
  output logic                             connected_o
);
  typedef enum logic [2:0] {
    SI_IDLE = 3'b001,
    SI_SEL  = 3'b010,
    SI_CONN = 3'b100
  } stb_ini_state_t;

  typedef struct packed {
    stb_ini_state_t              state;
    logic                        ack;
    logic                        drive;
    logic [stb_pkg::DATA_W-1:0]  dout;
    logic [stb_pkg::DATA_W-1:0]  rx;
    logic                        rxv;
    logic                        perr;
    logic                        taken;
    logic                        rbsy;
  } stb_ini_st_t;

  stb_ini_st_t st_reg;
  stb_ini_st_t st_next;
  logic [stb_pkg::DATA_W-1:0] ids;
  logic                       req;
  logic                       io;

  assign ids = (stb_pkg::DATA_W'(1) << own_id_i) | (stb_pkg::DATA_W'(1) << target_id_i);
  assign req = ~bus.req_n;
  assign io  = ~bus.io_n;

  always_comb
  begin
    st_next       = st_reg;
    st_next.rxv   = 1'b0;
    st_next.taken = 1'b0;
    case (st_reg.state)
      SI_IDLE:
        if (select_i && bus.bsy_n && bus.sel_n)
          st_next.state = SI_SEL;
        else if (!bus.sel_n && !bus.io_n && bus.bsy_n && !bus.db_n[own_id_i])
        begin
          st_next.rbsy  = 1'b1;
          st_next.state = SI_CONN;
        end
      SI_SEL:
        if (!bus.bsy_n)
          st_next.state = SI_CONN;
      SI_CONN:
      begin
        if (req && !st_reg.ack)
        begin
          st_next.ack = 1'b1;
          if (io)
          begin
            st_next.rx   = ~bus.db_n;
            st_next.rxv  = 1'b1;
            st_next.perr = (~bus.dbp_n) != stb_pkg::stb_odd_parity(~bus.db_n);
          end
          else
            st_next.taken = 1'b1;
        end
        else if (!req)
          st_next.ack = 1'b0;
        // target holds busy itself once it has dropped select
        if (bus.sel_n)
          st_next.rbsy = 1'b0;
        if (bus.bsy_n)
          st_next.state = SI_IDLE;
      end
      default:
        st_next.state = SI_IDLE;
    endcase
    st_next.dout  = tx_data_i;
    st_next.drive = (st_next.state == SI_CONN) && !io && req;
    if (!bus.rst_n)
    begin
      st_next.state = SI_IDLE;
      st_next.ack   = 1'b0;
      st_next.rbsy  = 1'b0;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      st_reg       <= '0;
      st_reg.state <= SI_IDLE;
    end
    else
      st_reg <= st_next;
  end

  assign bus.i_bsy_oe = st_reg.rbsy;
  assign bus.i_sel_oe = (st_reg.state == SI_SEL);
  assign bus.i_ack_oe = st_reg.ack;
  assign bus.i_atn_oe = atn_i;
  assign bus.i_rst_oe = bus_reset_i;
  assign bus.i_db_oe  = (st_reg.state == SI_SEL) ? ids
                      : {stb_pkg::DATA_W{st_reg.drive}};
  assign bus.i_db_o   = (st_reg.state == SI_SEL) ? ids : st_reg.dout;
  assign bus.i_dbp_oe = (st_reg.state == SI_SEL) | st_reg.drive;
  assign bus.i_dbp_o  = stb_pkg::stb_odd_parity(bus.i_db_o);
  assign tx_taken_o   = st_reg.taken;
  assign rx_valid_o   = st_reg.rxv;
  assign rx_data_o    = st_reg.rx;
  assign phase_o      = {~bus.msg_n, ~bus.cd_n, io};
  assign parity_err_o = st_reg.perr;
  assign connected_o  = (st_reg.state == SI_CONN);
endmodule
`default_nettype wire

// *** stb_bus_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module stb_bus_assertions (
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic       bsy_n,
  input wire logic       sel_n,
  input wire logic       cd_n,
  input wire logic       io_n,
  input wire logic       msg_n,
  input wire logic       req_n,
  input wire logic       ack_n,
  input wire logic       rst_n,
  input wire logic [7:0] db_n,
  input wire logic       dbp_n,
  input wire logic       t_bsy_oe,
  input wire logic       t_ctl_oe,
  input wire logic [7:0] t_db_oe
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_req_waits_ack: assert property (!req_n && ack_n && rst_n |=> !req_n)
    else $error("request dropped before acknowledge");
  chk_req_ends_ack: assert property (!req_n && !ack_n && rst_n |=> req_n)
    else $error("request held after acknowledge");
  chk_ack_answers: assert property ($fell(req_n) |-> ##[1:8] !ack_n)
    else $error("request not acknowledged in time");
  chk_ack_needs_req: assert property ($fell(ack_n) |-> !req_n)
    else $error("acknowledge without request");
  chk_phase_steady: assert property (!req_n && $past(!req_n) |-> $stable({cd_n, io_n, msg_n}))
    else $error("phase lines moved during request");
  chk_tdata_steady: assert property (!req_n && !io_n && $past(!req_n) |-> $stable(db_n))
    else $error("target data moved during request");
  chk_tgt_parity: assert property (!req_n && !io_n |-> ^(~{dbp_n, db_n}))
    else $error("target byte parity not odd");
  chk_ini_parity: assert property (!ack_n && !req_n && io_n |-> ^(~{dbp_n, db_n}))
    else $error("initiator byte parity not odd");
  chk_busy_held: assert property (!req_n |-> !bsy_n && sel_n)
    else $error("request outside an owned bus");
  chk_rst_clears: assert property (!rst_n |=> !t_ctl_oe && !t_bsy_oe && t_db_oe == 8'h00)
    else $error("target still drives after bus reset");

  cov_data_in: cover property (!req_n && !ack_n && !io_n);
  cov_data_out: cover property (!req_n && !ack_n && io_n);
  cov_resel: cover property (!sel_n && !io_n);
  cov_bus_reset: cover property (!rst_n);
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clock_i, rst_n_i, own_load, resel, xfer_valid, rel, rx_ready, select, atn, brst;
  logic       xfer_ready, t_rx_valid, t_conn, t_selp, t_atn, t_brst, t_busy, t_perr, tx_taken;
  logic       i_rx_valid, i_perr, i_conn, f_ready, f_conn, f_perr, f_sel, f_ack, f_dbp, perr_seen;
  logic [2:0] own_id, resel_id, phase, i_own, target_id, t_own_o, t_lun, t_peer, i_phase;
  logic [7:0] xfer_data, t_rx_data, tx_data, i_rx_data, f_db_oe, f_db;
  int         bad_count, checked;

  stb_bus_if bus_if ();
  stb_bus_if bus_flt ();
  // second bus: the bench plays a faulty initiator
  assign bus_flt.i_bsy_oe = 1'b0;
  assign bus_flt.i_sel_oe = f_sel;
  assign bus_flt.i_ack_oe = f_ack;
  assign bus_flt.i_atn_oe = 1'b0;
  assign bus_flt.i_rst_oe = 1'b0;
  assign bus_flt.i_db_oe  = f_db_oe;
  assign bus_flt.i_db_o   = f_db;
  assign bus_flt.i_dbp_oe = f_dbp;
  assign bus_flt.i_dbp_o  = f_dbp;

  stb_target u_stb_target (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus(bus_if),
    .own_id_i(own_id), .own_id_load_i(own_load), .own_id_o(t_own_o), .lun_o(t_lun),
    .resel_i(resel), .resel_id_i(resel_id), .phase_i(phase), .xfer_valid_i(xfer_valid),
    .xfer_ready_o(xfer_ready), .xfer_data_i(xfer_data), .release_i(rel),
    .rx_valid_o(t_rx_valid), .rx_ready_i(rx_ready), .rx_data_o(t_rx_data),
    .connected_o(t_conn), .peer_id_o(t_peer), .selected_o(t_selp), .atn_o(t_atn),
    .bus_reset_o(t_brst), .bus_busy_o(t_busy), .parity_err_o(t_perr));
  stb_target u_stb_target_flt (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus(bus_flt),
    .own_id_i(own_id), .own_id_load_i(own_load), .own_id_o(), .lun_o(),
    .resel_i(1'b0), .resel_id_i(3'h0), .phase_i(phase), .xfer_valid_i(xfer_valid),
    .xfer_ready_o(f_ready), .xfer_data_i(xfer_data), .release_i(rel),
    .rx_valid_o(), .rx_ready_i(1'b1), .rx_data_o(), .connected_o(f_conn), .peer_id_o(),
    .selected_o(), .atn_o(), .bus_reset_o(), .bus_busy_o(), .parity_err_o(f_perr));
  stb_initiator u_stb_initiator (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus(bus_if),
    .own_id_i(i_own), .select_i(select), .target_id_i(target_id), .atn_i(atn),
    .bus_reset_i(brst), .tx_data_i(tx_data), .tx_taken_o(tx_taken), .rx_valid_o(i_rx_valid),
    .rx_data_o(i_rx_data), .phase_o(i_phase), .parity_err_o(i_perr), .connected_o(i_conn));
  stb_bus_assertions u_stb_bus_assertions (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .bsy_n(bus_if.bsy_n), .sel_n(bus_if.sel_n), .cd_n(bus_if.cd_n), .io_n(bus_if.io_n),
    .msg_n(bus_if.msg_n), .req_n(bus_if.req_n), .ack_n(bus_if.ack_n), .rst_n(bus_if.rst_n),
    .db_n(bus_if.db_n), .dbp_n(bus_if.dbp_n), .t_bsy_oe(bus_if.t_bsy_oe),
    .t_ctl_oe(bus_if.t_ctl_oe), .t_db_oe(bus_if.t_db_oe));

  always #10 clock_i = ~clock_i;

  always @(posedge clock_i)
    if (t_perr === 1'b1 || i_perr === 1'b1)
      perr_seen <= 1'b1;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic do_xfer(input logic [2:0] ph, input logic [7:0] d, input bit must);
    int n;
    bit done;
    bit seen;
    phase = ph;
    xfer_data = d;
    tx_data = d;
    xfer_valid = 1'b1;
    for (n = 0; n < 40 && xfer_ready !== 1'b1; n++)
      cyc(1);
    cyc(1);
    xfer_valid = 1'b0;
    done = 0;
    seen = 0;
    for (n = 0; n < 40 && !done; n++)
    begin
      if (bus_if.req_n === 1'b0 && !seen)
      begin
        seen = 1;
        check(3'(~{bus_if.msg_n, bus_if.cd_n, bus_if.io_n}), ph);
        if (ph[0])
          check(8'(~bus_if.db_n), d);
      end
      if (ph[0] ? i_rx_valid === 1'b1 : tx_taken === 1'b1)
      begin
        done = 1;
        check(i_phase, ph);
        if (ph[0])
          check(i_rx_data, d);
      end
      cyc(1);
    end
    if (must)
      check(done, 1'b1);
  endtask

  task automatic t_id_setup();
    check(t_own_o, stb_pkg::OWN_ID_RESET);
    check(t_lun, stb_pkg::LUN_FIXED);
    check(bus_if.bsy_n, 1'b1);
    for (int i = 0; i < 9; i++)
    begin
      own_id = (i == 8) ? 3'h5 : i[2:0];
      own_load = 1'b1;
      cyc(1);
      own_load = 1'b0;
      cyc(1);
      check(t_own_o, own_id);
    end
  endtask

  task automatic t_select();
    bit sp;
    sp = 0;
    select = 1'b1;
    for (int n = 0; n < 60 && t_conn !== 1'b1; n++)
    begin
      if (bus_if.sel_n === 1'b0 && bus_if.bsy_n === 1'b1)
        check(8'(~bus_if.db_n), 8'ha0);
      if (t_selp === 1'b1)
        sp = 1;
      cyc(1);
    end
    // the select pulse stands in the very cycle that connection shows up
    if (t_selp === 1'b1)
      sp = 1;
    select = 1'b0;
    cyc(1);
    check(sp, 1'b1);
    check(t_peer, 3'h7);
    check({t_busy, bus_if.bsy_n, i_conn}, 3'h5);
  endtask

  task automatic t_transfers();
    logic [7:0] exp_q [3];
    int k;
    exp_q = '{8'h3c, 8'h7f, 8'hfe};
    do_xfer(3'h1, 8'h96, 1'b1);
    do_xfer(stb_pkg::STB_PH_STAT, 8'h80, 1'b1);
    do_xfer(stb_pkg::STB_PH_MIN, 8'h01, 1'b1);
    rx_ready = 1'b0;
    do_xfer(stb_pkg::STB_PH_DATA, exp_q[0], 1'b1);
    do_xfer(stb_pkg::STB_PH_CMD, exp_q[1], 1'b1);
    // buffer full: an out byte is held off, not taken and lost
    cyc(3);
    check(xfer_ready, 1'b0);
    check(t_rx_data, exp_q[0]);
    rx_ready = 1'b1;
    cyc(1);
    rx_ready = 1'b0;
    do_xfer(stb_pkg::STB_PH_MOUT, exp_q[2], 1'b1);
    rx_ready = 1'b1;
    k = 1;
    for (int n = 0; n < 40; n++)
    begin
      if (t_rx_valid === 1'b1 && k < 3)
      begin
        check(t_rx_data, exp_q[k]);
        k++;
      end
      cyc(1);
    end
    check(k, 3);
    check(perr_seen, 1'b0);
  endtask

  task automatic t_atn_release();
    atn = 1'b1;
    cyc(3);
    check({t_atn, bus_if.atn_n}, 2'h2);
    atn = 1'b0;
    cyc(3);
    check(t_atn, 1'b0);
    rel = 1'b1;
    cyc(1);
    rel = 1'b0;
    cyc(3);
    check({t_conn, t_busy, bus_if.bsy_n}, 3'h1);
  endtask

  task automatic t_resel_reset();
    bit sw;
    sw = 0;
    resel_id = 3'h7;
    resel = 1'b1;
    for (int n = 0; n < 60 && t_conn !== 1'b1; n++)
    begin
      if (bus_if.sel_n === 1'b0 && bus_if.io_n === 1'b0)
      begin
        sw = 1;
        check(8'(~bus_if.db_n), 8'ha0);
      end
      cyc(1);
    end
    resel = 1'b0;
    check({sw, t_peer, i_conn}, 5'h1f);
    do_xfer(3'h1, 8'h5a, 1'b1);
    brst = 1'b1;
    cyc(2);
    check({t_brst, bus_if.rst_n, t_conn}, 3'h4);
    brst = 1'b0;
    cyc(3);
    check({t_brst, bus_if.bsy_n}, 2'h1);
  endtask

  task automatic t_fault();
    bit pe;
    pe = 0;
    f_sel = 1'b1;
    f_db_oe = 8'ha0;
    f_db = 8'ha0;
    f_dbp = 1'b1;
    for (int n = 0; n < 40 && f_conn !== 1'b1; n++)
      cyc(1);
    f_sel = 1'b0;
    f_db_oe = 8'h00;
    f_dbp = 1'b0;
    phase = stb_pkg::STB_PH_DATA;
    xfer_valid = 1'b1;
    for (int n = 0; n < 40 && f_ready !== 1'b1; n++)
      cyc(1);
    cyc(1);
    xfer_valid = 1'b0;
    for (int n = 0; n < 40 && bus_flt.req_n !== 1'b0; n++)
      cyc(1);
    // two true lines out of nine: even, so the byte is bad
    f_db_oe = 8'hff;
    f_db = 8'h01;
    f_dbp = 1'b1;
    cyc(2);
    f_ack = 1'b1;
    for (int n = 0; n < 8; n++)
    begin
      if (f_perr === 1'b1)
        pe = 1;
      cyc(1);
    end
    check(pe, 1'b1);
    f_ack = 1'b0;
    f_db_oe = 8'h00;
    f_dbp = 1'b0;
    cyc(3);
    rel = 1'b1;
    cyc(1);
    rel = 1'b0;
  endtask

  initial
  begin
    {clock_i, rst_n_i, own_load, resel, xfer_valid, rel, select, atn, brst} = '0;
    {f_sel, f_ack, f_dbp, perr_seen, rx_ready} = 5'h1;
    {own_id, resel_id, phase, xfer_data, tx_data, f_db_oe, f_db} = '0;
    own_id = 3'h5;
    i_own = 3'h7;
    target_id = 3'h5;
    bad_count = 0;
    checked = 0;
    cyc(10);
    rst_n_i = 1'b1;
    cyc(1);
    t_id_setup();
    t_select();
    t_transfers();
    t_atn_release();
    t_resel_reset();
    t_fault();
    report_and_stop();
  end

  initial
  begin
    #400000;
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
